// *** logic/fspc_pkg.sv ***
// Shared constants for the flash self-programming control block
`default_nettype none
package fspc_pkg;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PTR_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF = 8'h08;
  localparam int EN_BIT = 0;
  localparam int ERS_BIT = 1;
  localparam int WRT_BIT = 2;
  localparam int LCK_BIT = 3;
  localparam int RRE_BIT = 4;
  localparam int BUSY_BIT = 6;
  localparam int IE_BIT = 7;
  localparam logic [4:0] CMD_FILL = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_RRE = 5'h11;
  localparam int STORE_WIN = 4;
  localparam int LOAD_WIN = 3;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_MIN_NS = 3_700_000;
  localparam int PROG_MAX_NS = 4_500_000;
  localparam int PROG_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_W = 7;
  localparam int WORD_LSB = 1;
  localparam int WORD_W = 5;
  localparam logic [6:0] RWW_PAGES = 7'h60;
  localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
  localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
  localparam logic [1:0] LOCK_PAD = 2'h3;
  localparam logic [5:0] LOCK_INIT = 6'h3f;
endpackage
`default_nettype wire

// *** logic/fspc_cnt_if.sv ***
// Start, active and done signals between the sequencer and its counters
`default_nettype none
interface fspc_cnt_if;
  logic start;
  logic active;
  logic done;
  modport ctl (output start, input active, input done);
  modport cnt (input start, output active, output done);
endinterface
`default_nettype wire

// *** logic/fspc_window.sv ***
// Down-counter that opens a timed instruction window after a command write
`default_nettype none
module fspc_window #(
  parameter int LEN = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  fspc_cnt_if.cnt c
);
  if (LEN < 1 || LEN > 15) begin
    $error("fspc_window: LEN out of range");
  end
  localparam logic [3:0] LEN_C = 4'(LEN);
  logic [3:0] cnt_q;
  // A new start always reloads, so a rewrite restarts the window
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (c.start) begin
      cnt_q <= LEN_C;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign c.active = (cnt_q != 4'h0);
  assign c.done = (cnt_q == 4'h1) && !c.start;
endmodule
`default_nettype wire

// *** logic/fspc_prog_timer.sv ***
// Programming-time counter that survives reset once started
`default_nettype none
module fspc_prog_timer #(
  parameter int CYCLES = fspc_pkg::PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  fspc_cnt_if.cnt c
);
  if (CYCLES < 2 || CYCLES > 262143) begin
    $error("fspc_prog_timer: CYCLES out of range");
  end
  localparam logic [17:0] CYC_C = 18'(CYCLES);
  // Power-up value given so reset can be gated by the running state
  logic [17:0] cnt_q = 18'h0_0000;
  always_ff @(posedge clk_sys) begin
    if (rst && cnt_q == 18'h0_0000) begin
      cnt_q <= 18'h0_0000;
    end else if (c.start && cnt_q == 18'h0_0000) begin
      cnt_q <= CYC_C;
    end else if (cnt_q != 18'h0_0000) begin
      cnt_q <= cnt_q - 18'h0_0001;
    end
  end
  assign c.active = (cnt_q != 18'h0_0000);
  assign c.done = (cnt_q == 18'h0_0001);
endmodule
`default_nettype wire

// *** logic/fspc_top.sv ***
// Flash self-programming sequencer with AHB-Lite control registers
`default_nettype none
module fspc_top #(
  parameter int PROG_CYCLES = fspc_pkg::PROG_CYCLES,
  parameter logic [7:0] FUSE_LOW = 8'hff,
  parameter logic [7:0] FUSE_HIGH = 8'hff,
  parameter logic [7:0] FUSE_EXT = 8'hff
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic spm_exec,
  input wire logic lpm_exec,
  input wire logic eeprom_write_busy_flag,
  output logic lpm_sel,
  output logic [7:0] lpm_data,
  output logic cpu_halt,
  output logic rww_read_block,
  output logic spm_irq,
  output logic flash_erase,
  output logic flash_write,
  output logic buf_load,
  output logic [6:0] flash_page,
  output logic [4:0] flash_word,
  output logic [15:0] buf_data,
  output logic [5:0] lock_bits
);
  // The timer is 18 bits wide and needs at least two cycles to hand over done
  if (PROG_CYCLES < 2 || PROG_CYCLES > 262143) begin
    $error("fspc_top: PROG_CYCLES out of range");
  end

  fspc_cnt_if st_if();
  fspc_cnt_if ld_if();
  fspc_cnt_if tm_if();

  // Store window four cycles, load window three; the store window restarts on each command, the load window only on a lock command
  fspc_window #(.LEN(fspc_pkg::STORE_WIN)) u_store_win (
    .clk_sys(clk_sys),
    .rst(rst),
    .c(st_if)
  );
  fspc_window #(.LEN(fspc_pkg::LOAD_WIN)) u_load_win (
    .clk_sys(clk_sys),
    .rst(rst),
    .c(ld_if)
  );
  // One timer serves erase, write and lock programming alike
  fspc_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .c(tm_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [4:0] cmd_q;
  logic irq_en_q;
  logic busy_flag_q;
  logic [15:0] ptr_q;
  logic [15:0] data_q;
  logic op_no_read_while_write_section_q;
  logic op_page_q;
  logic op_lock_q;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic self_prog_enable_bit_rd;

  assign addr_ok = hsel && hready && htrans[1];
  // Enable reads set while a timed operation runs
  assign self_prog_enable_bit_rd = cmd_q[fspc_pkg::EN_BIT] || tm_if.active;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      fspc_pkg::CTRL_OFF: begin
        rd_mux[fspc_pkg::RRE_BIT:fspc_pkg::ERS_BIT] = cmd_q[4:1];
        rd_mux[fspc_pkg::EN_BIT] = self_prog_enable_bit_rd;
        rd_mux[fspc_pkg::BUSY_BIT] = busy_flag_q;
        rd_mux[fspc_pkg::IE_BIT] = irq_en_q;
      end
      fspc_pkg::PTR_OFF: begin
        rd_mux[15:0] = ptr_q;
      end
      fspc_pkg::DATA_OFF: begin
        rd_mux[15:0] = data_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data is sampled in the address phase so it stands in the data phase
  // The response never leaves OKAY: no access here can fail
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command acceptance and instruction windows
  logic wr_ctrl;
  logic cmd_legal;
  logic accept;
  logic spm_go;
  logic lpm_go;
  logic op_start;
  logic pg_start;

  // Writes land at the end of the data phase, when hwdata is valid
  assign wr_ctrl = wr_pend_q && (wr_addr_q == fspc_pkg::CTRL_OFF);
  // Only five patterns of the low bits count as commands
  assign cmd_legal = (hwdata[4:0] == fspc_pkg::CMD_FILL) ||
                     (hwdata[4:0] == fspc_pkg::CMD_ERASE) ||
                     (hwdata[4:0] == fspc_pkg::CMD_WRITE) ||
                     (hwdata[4:0] == fspc_pkg::CMD_LOCK) ||
                     (hwdata[4:0] == fspc_pkg::CMD_RRE);
  // Commands are refused while the timer runs or while the EEPROM writes
  assign accept = wr_ctrl && cmd_legal && !tm_if.active &&
                  !eeprom_write_busy_flag;
  assign st_if.start = accept;
  assign ld_if.start = accept && (hwdata[4:0] == fspc_pkg::CMD_LOCK);
  assign tm_if.start = op_start;

  // An EEPROM write that starts inside the window still stops the store
  assign spm_go = spm_exec && st_if.active && cmd_q[fspc_pkg::EN_BIT] &&
                  !tm_if.active && !eeprom_write_busy_flag;
  assign pg_start = spm_go && ((cmd_q == fspc_pkg::CMD_ERASE) ||
                               (cmd_q == fspc_pkg::CMD_WRITE));
  assign op_start = pg_start || (spm_go && cmd_q == fspc_pkg::CMD_LOCK);
  // An EEPROM write also stops fuse and lock reads
  assign lpm_go = lpm_exec && ld_if.active && (cmd_q == fspc_pkg::CMD_LOCK) &&
                  !tm_if.active && !eeprom_write_busy_flag;

  // Erase, write and lock set keep their bits until the timer ends
  always_ff @(posedge clk_sys) begin
    if (rst && !tm_if.active) begin
      cmd_q <= 5'h00;
    end else if (accept) begin
      cmd_q <= hwdata[4:0];
    end else if (tm_if.done) begin
      cmd_q <= 5'h00;
    end else if (lpm_go) begin
      cmd_q <= 5'h00;
    end else if (spm_go && !op_start) begin
      cmd_q <= 5'h00;
    end else if (st_if.done && !op_start && !tm_if.active) begin
      cmd_q <= 5'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_q <= hwdata[fspc_pkg::IE_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_q <= 16'h0000;
      data_q <= 16'h0000;
    end else if (wr_pend_q) begin
      if (wr_addr_q == fspc_pkg::PTR_OFF) begin
        ptr_q <= hwdata[15:0];
      end
      if (wr_addr_q == fspc_pkg::DATA_OFF) begin
        data_q <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Running operation: section, halt and read blocking
  logic [6:0] page_sel;
  // Page field only; the word bits belong to the fill command
  assign page_sel = ptr_q[fspc_pkg::PAGE_LSB +: fspc_pkg::PAGE_W];

  // Held through reset while the timer runs so the write finishes cleanly
  always_ff @(posedge clk_sys) begin
    if (rst && !tm_if.active) begin
      op_no_read_while_write_section_q <= 1'b0;
      op_page_q <= 1'b0;
      op_lock_q <= 1'b0;
    end else if (op_start) begin
      op_no_read_while_write_section_q <= (page_sel >= fspc_pkg::RWW_PAGES);
      op_page_q <= pg_start;
      op_lock_q <= !pg_start;
    end else if (tm_if.done) begin
      op_no_read_while_write_section_q <= 1'b0;
      op_page_q <= 1'b0;
      op_lock_q <= 1'b0;
    end
  end

  // Only page operations on the locked-out section stop the core
  always_ff @(posedge clk_sys) begin
    if (rst && !tm_if.active) begin
      cpu_halt <= 1'b0;
    end else if (pg_start) begin
      cpu_halt <= (page_sel >= fspc_pkg::RWW_PAGES);
    end else if (tm_if.done) begin
      cpu_halt <= 1'b0;
    end
  end

  // Lock programming never sets the flag, so all flash stays readable
  always_ff @(posedge clk_sys) begin
    if (rst && !tm_if.active) begin
      busy_flag_q <= 1'b0;
    end else if (pg_start) begin
      busy_flag_q <= 1'b1;
    end else if (spm_go && cmd_q == fspc_pkg::CMD_RRE) begin
      busy_flag_q <= 1'b0;
    end
  end

  // The start pulse covers the cycle before the flag is seen
  always_ff @(posedge clk_sys) begin
    if (rst && !tm_if.active) begin
      rww_read_block <= 1'b0;
    end else begin
      rww_read_block <= busy_flag_q || pg_start;
    end
  end

  // Level request: stays up while the interrupt enable is set and the enable bit reads clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      spm_irq <= 1'b0;
    end else begin
      spm_irq <= irq_en_q && !self_prog_enable_bit_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash array strobes and page buffer load
  // One-cycle strobes towards the flash array
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      buf_load <= 1'b0;
    end else begin
      flash_erase <= spm_go && cmd_q == fspc_pkg::CMD_ERASE;
      flash_write <= spm_go && cmd_q == fspc_pkg::CMD_WRITE;
      buf_load <= spm_go && cmd_q == fspc_pkg::CMD_FILL;
    end
  end

  // Address latched at start, so software may reuse the pointer afterwards
  always_ff @(posedge clk_sys) begin
    if (rst && !tm_if.active) begin
      flash_page <= 7'h00;
      flash_word <= 5'h00;
      buf_data <= 16'h0000;
    end else if (pg_start) begin
      flash_page <= page_sel;
      flash_word <= 5'h00;
    end else if (spm_go && cmd_q == fspc_pkg::CMD_FILL) begin
      flash_word <= ptr_q[fspc_pkg::WORD_LSB +: fspc_pkg::WORD_W];
      buf_data <= data_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock bits and fuse/lock read-back
  // Lock bits are nonvolatile: no reset, power-up value only
  logic [5:0] lock_q = fspc_pkg::LOCK_INIT;
  logic [7:0] lock_byte;
  logic [7:0] rd_byte;

  // Only the boot locks can be programmed; a zero programs, never erases
  always_ff @(posedge clk_sys) begin
    if (op_start && !pg_start) begin
      lock_q[5:2] <= lock_q[5:2] & data_q[5:2];
    end
  end
  assign lock_bits = lock_q;

  assign lock_byte = {fspc_pkg::LOCK_PAD, lock_q};

  always_comb begin
    rd_byte = lock_byte;
    unique case (ptr_q[1:0])
      fspc_pkg::SEL_FUSE_LOW: begin
        rd_byte = FUSE_LOW;
      end
      fspc_pkg::SEL_LOCK: begin
        rd_byte = lock_byte;
      end
      fspc_pkg::SEL_FUSE_EXT: begin
        rd_byte = FUSE_EXT;
      end
      fspc_pkg::SEL_FUSE_HIGH: begin
        rd_byte = FUSE_HIGH;
      end
    endcase
  end

  // Without this pulse the core's load reads the flash as usual
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lpm_sel <= 1'b0;
      lpm_data <= 8'h00;
    end else begin
      lpm_sel <= lpm_go;
      if (lpm_go) begin
        lpm_data <= rd_byte;
      end
    end
  end

  logic unused_ok;
  // The load window's expiry is not used: the store window ends the command
  assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:16], op_no_read_while_write_section_q,
                       op_page_q, op_lock_q, ld_if.done};
endmodule
`default_nettype wire

// *** verif/fspc_core_model.sv ***
// Behavioural processor core that issues store and load instruction strobes
`default_nettype none
module fspc_core_model (
  input wire logic clk_sys,
  output logic spm_exec,
  output logic lpm_exec,
  output logic eeprom_write_busy_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spm_exec = 1'b0;
    lpm_exec = 1'b0;
    eeprom_write_busy_flag = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Called just after an edge; d of 3 is the last slot of the store window
  task automatic spm(input int d);
    repeat (d) @(posedge clk_sys);
    spm_exec <= 1'b1;
    @(posedge clk_sys);
    spm_exec <= 1'b0;
  endtask
  // A late strobe (d of 3) falls outside the load window on purpose
  task automatic lpm(input int d);
    repeat (d) @(posedge clk_sys);
    lpm_exec <= 1'b1;
    @(posedge clk_sys);
    lpm_exec <= 1'b0;
  endtask
  // Software normally waits for this flag to drop before a command write
  task automatic ee(input logic v);
    eeprom_write_busy_flag <= v;
  endtask
endmodule
`default_nettype wire

// *** verif/fspc_top_properties.sv ***
// Concurrent checks on the sequencer's top-level ports
`default_nettype none
module fspc_top_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic lpm_exec,
  input wire logic eeprom_write_busy_flag,
  input wire logic lpm_sel,
  input wire logic cpu_halt,
  input wire logic rww_read_block,
  input wire logic spm_irq,
  input wire logic flash_erase,
  input wire logic flash_write,
  input wire logic [6:0] flash_page,
  input wire logic [5:0] lock_bits
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  sequence s_start;
    flash_write || flash_erase;
  endsequence
  sequence s_start_hi;
    (flash_write || flash_erase) && flash_page >= fspc_pkg::RWW_PAGES;
  endsequence
  sequence s_start_lo;
    (flash_write || flash_erase) && flash_page < fspc_pkg::RWW_PAGES;
  endsequence
  property p_irq_quiet;
    s_start |=> !spm_irq [*8];
  endproperty
  property p_halt_hi;
    s_start_hi |=> cpu_halt [*6];
  endproperty
  property p_run_lo;
    s_start_lo |-> !cpu_halt [*6];
  endproperty
  property p_block;
    s_start |=> rww_read_block [*8];
  endproperty
  property p_halt_hold;
    $rose(cpu_halt) |-> cpu_halt [*8];
  endproperty
  property p_lock_dir;
    $changed(lock_bits) |-> ((lock_bits & ~$past(lock_bits)) == 6'h0)
      && (lock_bits[1:0] == $past(lock_bits[1:0]));
  endproperty
  property p_lock_free;
    $changed(lock_bits) |-> !cpu_halt && $stable(rww_read_block);
  endproperty
  property p_ee_block;
    lpm_exec && eeprom_write_busy_flag |=> !lpm_sel;
  endproperty
  property p_lpm_cause;
    lpm_sel |-> $past(lpm_exec) || $past(lpm_exec, 2);
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("irq raised while programming");
  a_halt_hi: assert property (p_halt_hi)
    else $error("core not halted for upper page");
  a_run_lo: assert property (p_run_lo)
    else $error("core halted for lower page");
  a_block: assert property (p_block)
    else $error("section not blocked while programming");
  a_halt_hold: assert property (p_halt_hold)
    else $error("halt dropped early");
  a_lock_dir: assert property (p_lock_dir)
    else $error("lock bits changed wrongly");
  a_lock_free: assert property (p_lock_free)
    else $error("lock programming blocked reads");
  a_ee_block: assert property (p_ee_block)
    else $error("fuse read during eeprom write");
  a_lpm_cause: assert property (p_lpm_cause)
    else $error("read answer without load");
endmodule
bind fspc_top fspc_top_properties u_props (.clk_sys(clk_sys), .rst(rst),
  .lpm_exec(lpm_exec), .eeprom_write_busy_flag(eeprom_write_busy_flag), .lpm_sel(lpm_sel),
  .cpu_halt(cpu_halt), .rww_read_block(rww_read_block), .spm_irq(spm_irq),
  .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page),
  .lock_bits(lock_bits));
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the flash self-programming sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = fspc_pkg::CTRL_OFF;
  localparam logic [7:0] PTR = fspc_pkg::PTR_OFF;
  localparam logic [7:0] F_LO = 8'h5a;
  localparam logic [7:0] F_HI = 8'h96;
  localparam logic [7:0] F_EX = 8'hc3;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic lpm_sel;
  logic [7:0] lpm_data;
  logic cpu_halt;
  logic rww_read_block;
  logic spm_irq;
  logic flash_erase;
  logic flash_write;
  logic [6:0] flash_page;
  logic [5:0] lock_bits;
  logic buf_load;
  logic [4:0] flash_word;
  logic [15:0] buf_data;
  wire logic spm_exec;
  wire logic lpm_exec;
  wire logic ee_busy;
  logic [31:0] rd;
  logic [7:0] tab [4] = '{F_LO, 8'hff, F_EX, F_HI};
  int err_total = 0;
  int checks_done = 0;
  always #10 clk_sys = ~clk_sys;
  fspc_core_model core (.clk_sys(clk_sys), .spm_exec(spm_exec), .lpm_exec(lpm_exec),
    .eeprom_write_busy_flag(ee_busy));
  fspc_top #(.PROG_CYCLES(20), .FUSE_LOW(F_LO), .FUSE_HIGH(F_HI), .FUSE_EXT(F_EX)) DUT (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .spm_exec(spm_exec), .lpm_exec(lpm_exec),
    .eeprom_write_busy_flag(ee_busy), .lpm_sel(lpm_sel), .lpm_data(lpm_data),
    .cpu_halt(cpu_halt), .rww_read_block(rww_read_block), .spm_irq(spm_irq),
    .flash_erase(flash_erase), .flash_write(flash_write), .buf_load(buf_load),
    .flash_page(flash_page), .flash_word(flash_word), .buf_data(buf_data),
    .lock_bits(lock_bits));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic edge_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        err_total++;
        report_and_stop();
      end
    end while (hreadyout !== 1'b1);
  endtask
  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask
  // Polls the enable bit until the running operation has finished
  task automatic wait_idle;
    int n;
    n = 0;
    bus(0, CTL, 32'h0);
    while (rd[0] !== 1'b0) begin
      n++;
      if (n > 40) begin
        err_total++;
        report_and_stop();
      end
      bus(0, CTL, 32'h0);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_basics;
    bus(0, CTL, 32'h0);
    check(rd, 32'h0);
    check(32'(lock_bits), 32'h3f);
    bus(1, 8'h0c, 32'hffff_ffff);
    bus(0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
  endtask
  task automatic t_fuse(input logic [1:0] sel, input int d, input logic want,
      input logic [7:0] exp);
    logic hit;
    hit = 1'b0;
    bus(1, PTR, {30'h0, sel});
    bus(1, CTL, {27'h0, fspc_pkg::CMD_LOCK});
    core.lpm(d);
    repeat (3) begin
      @(posedge clk_sys);
      if (lpm_sel === 1'b1) begin
        hit = 1'b1;
        check(32'(lpm_data), 32'(exp));
      end
    end
    check(32'(hit), 32'(want));
    bus(0, CTL, 32'h0);
    check(rd & 32'h1f, 32'h0);
  endtask
  task automatic t_lock(input logic [7:0] dv);
    logic [5:0] exp;
    exp = fspc_pkg::LOCK_INIT & {dv[5:2], 2'h3};
    bus(1, PTR, 32'h1);
    bus(1, fspc_pkg::DATA_OFF, {24'h0, dv});
    bus(1, CTL, {27'h0, fspc_pkg::CMD_LOCK});
    core.spm(3);
    repeat (3) @(posedge clk_sys);
    check(32'(lock_bits), 32'(exp));
    check(32'(rww_read_block), 32'h0);
    check(32'(cpu_halt), 32'h0);
    wait_idle();
    t_fuse(2'h1, 1, 1'b1, {2'h3, exp});
  endtask
  // Boot-loader style run: command, completion poll, then section re-enable
  task automatic t_prog(input logic [4:0] cmd, input logic [6:0] pg, input logic mid);
    logic [1:0] pulse;
    pulse = 2'h0;
    bus(1, PTR, {19'h0, pg, 6'h0});
    bus(1, fspc_pkg::DATA_OFF, 32'h0000_a5a5);
    bus(1, CTL, {24'h0, 3'h4, cmd});
    core.spm(3);
    repeat (2) begin
      @(posedge clk_sys);
      if (flash_write === 1'b1 || flash_erase === 1'b1) begin
        pulse = {flash_erase, flash_write};
        check(32'(flash_page), 32'(pg));
        check(32'(flash_word), 32'h0);
      end
    end
    check(32'(pulse), (cmd == fspc_pkg::CMD_WRITE) ? 32'h1 : 32'h2);
    if (mid) begin
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
    end
    check(32'(cpu_halt), 32'(pg >= fspc_pkg::RWW_PAGES));
    check(32'(rww_read_block), 32'h1);
    bus(1, CTL, 32'h80);
    bus(0, CTL, 32'h0);
    check(rd & 32'h41, 32'h41);
    check(32'(spm_irq), 32'h0);
    wait_idle();
    repeat (2) @(posedge clk_sys);
    check(32'(spm_irq), 32'h1);
    check(32'(cpu_halt), 32'h0);
    bus(1, CTL, {27'h0, fspc_pkg::CMD_RRE});
    core.spm(0);
    repeat (2) @(posedge clk_sys);
    bus(0, CTL, 32'h0);
    check(rd & 32'h40, 32'h0);
    check(32'(rww_read_block), 32'h0);
  endtask
  // Buffer fill: one store moves the data word to the addressed buffer slot
  task automatic t_fill;
    logic hit;
    hit = 1'b0;
    bus(1, PTR, 32'h0000_0014);
    bus(1, fspc_pkg::DATA_OFF, 32'h0000_3c5a);
    bus(1, CTL, {27'h0, fspc_pkg::CMD_FILL});
    core.spm(1);
    repeat (2) begin
      @(posedge clk_sys);
      if (buf_load === 1'b1) begin
        hit = 1'b1;
        check(32'(flash_word), 32'h0000_000a);
        check(32'(buf_data), 32'h0000_3c5a);
      end
    end
    check(32'(hit), 32'h1);
    bus(0, CTL, 32'h0);
    check(rd & 32'h1f, 32'h0);
  endtask
  // Commands that must leave no trace: bad pattern, or eeprom write running
  task automatic t_refused(input logic [4:0] pat, input logic ee);
    logic seen;
    seen = 1'b0;
    core.ee(ee);
    bus(1, CTL, {27'h0, pat});
    core.spm(0);
    core.lpm(0);
    repeat (3) begin
      @(posedge clk_sys);
      seen = seen | flash_write | flash_erase | lpm_sel;
    end
    check(32'(seen), 32'h0);
    check(32'(rww_read_block), 32'h0);
    bus(0, CTL, 32'h0);
    check(rd & 32'h1f, 32'h0);
    // A lock read already armed is still refused once the EEPROM write starts
    if (ee) begin
      seen = 1'b0;
      core.ee(1'b0);
      bus(1, CTL, {27'h0, fspc_pkg::CMD_LOCK});
      core.ee(1'b1);
      core.lpm(0);
      repeat (2) begin
        @(posedge clk_sys);
        seen = seen | lpm_sel;
      end
      check(32'(seen), 32'h0);
      core.ee(1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_basics();
    for (int s = 0; s < 4; s++) begin
      t_fuse(2'(s), s % 3, 1'b1, tab[s]);
    end
    t_fuse(2'h0, 3, 1'b0, 8'h0);
    t_lock(8'hc7);
    t_fill();
    t_prog(fspc_pkg::CMD_WRITE, 7'h5f, 1'b0);
    t_prog(fspc_pkg::CMD_WRITE, 7'h60, 1'b0);
    t_prog(fspc_pkg::CMD_ERASE, 7'h60, 1'b1);
    t_prog(fspc_pkg::CMD_ERASE, 7'h05, 1'b0);
    t_refused(5'h07, 1'b0);
    t_refused(fspc_pkg::CMD_WRITE, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
